/* rtl/rptc_pkg.sv */
/*
  Shared constants and types for the rear port trigger control block.
  Assumes a 50 MHz APB clock domain.
*/
package rptc_pkg;
  // Clock and timing
  localparam int unsigned CLK_HZ       = 50_000_000;
  localparam int unsigned TRIG_MIN_MS  = 5;
  localparam int unsigned TRIG_MIN_CYC = (TRIG_MIN_MS * (CLK_HZ / 1000));
  localparam int unsigned SEC_S        = 1;
  localparam int unsigned SEC_CYC      = CLK_HZ * SEC_S;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_TIMER    = 8'h04;
  localparam logic [7:0] OFS_LIST     = 8'h08;
  localparam logic [7:0] OFS_DOUT     = 8'h0c;
  localparam logic [7:0] OFS_CMD      = 8'h10;
  localparam logic [7:0] OFS_STAT     = 8'h14;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1c;

  // Command bits
  localparam int CMD_BUS_TRIG = 0;
  localparam int CMD_OUT_ON   = 1;
  localparam int CMD_OUT_OFF  = 2;
  localparam int CMD_LIST_ARM = 3;
  localparam int CMD_LIST_STOP = 4;

  // Interrupt bits
  localparam int IRQ_W         = 4;
  localparam int IRQ_TRIG      = 0;
  localparam int IRQ_TIMER     = 1;
  localparam int IRQ_INHIBIT   = 2;
  localparam int IRQ_LIST_DONE = 3;

  // Status field positions
  localparam int STAT_PIN    = 0;
  localparam int STAT_OUT_EN = 1;
  localparam int STAT_LIST   = 2;
  localparam int STAT_STEP_L = 3;
  localparam int STAT_TMR_L  = 11;

  // Widths and reset values
  localparam int TMR_W  = 16;
  localparam int STEP_W = 8;
  localparam logic [11:0]       CTRL_RST  = 12'h000;
  localparam logic [TMR_W-1:0]  TIMER_RST = 16'h0000;
  localparam logic [STEP_W-1:0] LIST_RST  = 8'h01;

  typedef enum logic [1:0] {
    PM_TRIG = 2'b00,
    PM_INH  = 2'b01,
    PM_DIO  = 2'b10
  } rptc_port_mode_t;

  typedef enum logic [1:0] {
    TS_KEY = 2'b00,
    TS_EXT = 2'b01,
    TS_BUS = 2'b10
  } rptc_trig_src_t;

  typedef enum logic [1:0] {
    IM_OFF   = 2'b00,
    IM_LATCH = 2'b01,
    IM_LIVE  = 2'b10
  } rptc_inh_mode_t;

  typedef enum logic [2:0] {
    FS_OFF  = 3'b000,
    FS_QUES = 3'b001,
    FS_OPER = 3'b010,
    FS_ESB  = 3'b011,
    FS_RQS  = 3'b100
  } rptc_fault_src_t;

  // Control register layout, bit 0 at the bottom
  typedef struct packed {
    logic            timer_en;
    logic            list_repeat;
    logic            list_step;
    rptc_fault_src_t fault_src;
    rptc_inh_mode_t  inh_mode;
    rptc_trig_src_t  trig_src;
    rptc_port_mode_t port_mode;
  } rptc_cfg_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } rptc_apb_req_t;
endpackage : rptc_pkg

/* rtl/rptc_list_seq.sv */
/*
  List sequence stepper: tracks the active step of a stored list.
  Assumes trig and step_tick are single-cycle pulses on pclk.
*/
`timescale 1ns/1ps
module rptc_list_seq (
  // Clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // Control
  input  wire logic                       trig,
  input  wire logic                       arm,
  input  wire logic                       stop,
  input  wire logic                       step_mode,
  input  wire logic                       repeat_en,
  input  wire logic [rptc_pkg::STEP_W-1:0] steps,
  input  wire logic                       step_tick,
  // Status
  output logic                            running,
  output logic [rptc_pkg::STEP_W-1:0]     step,
  output logic                            done
);
  import rptc_pkg::*;

  logic                armed_q;
  logic                run_q;
  logic [STEP_W-1:0]   step_q;
  logic                done_q;
  wire                 last  = (step_q + 8'h01 >= steps);
  wire                 adv_c = run_q & ~step_mode & step_tick;
  wire                 adv_s = armed_q & step_mode & trig;
  wire                 adv   = adv_c | adv_s;
  wire                 go    = armed_q & ~run_q & ~step_mode & trig;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_q <= 1'b0;
      run_q   <= 1'b0;
      step_q  <= '0;
      done_q  <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (stop) begin
        armed_q <= 1'b0;
        run_q   <= 1'b0;
        step_q  <= '0;
      end else if (arm) begin
        armed_q <= 1'b1;
        run_q   <= 1'b0;
        step_q  <= '0;
      end else if (go) begin
        run_q <= 1'b1;
      end else if (adv) begin
        if (!last) begin
          step_q <= step_q + 8'h01;
        end else begin
          step_q <= '0;
          // Single run pauses continuous, ends step mode
          if (!repeat_en) begin
            run_q   <= 1'b0;
            armed_q <= ~step_mode;
            done_q  <= 1'b1;
          end
        end
      end
    end
  end

  assign running = run_q | (armed_q & step_mode);
  assign step    = step_q;
  assign done    = done_q;
endmodule : rptc_list_seq

/* rtl/rptc_top.sv */
/*
  Rear digital port controller: port function mux, trigger source
  selection, external pulse qualification, inhibit, fault output,
  digital I/O, list stepping and output-off timer, behind APB.
  Assumes status summary bits, key and step tick come from pclk logic;
  the port pin is asynchronous.
*/
//
// Overview of operation
// - Port serves at most one of three functions; code 2'b11 selects none
// - Trigger function uses pin one, fault pin idle
// - Inhibit function lets shutdown pin gate output
// - Inhibit function drives fault pin
// - Digital I/O reads input, sets output
// - One selected trigger source of three
// - Key press makes one trigger pulse
// - External pulse of 5 ms is one trigger
// - Bus trigger command raises a trigger
// - External pin pulses step and run lists
// - Enabled timer counts seconds then output off
// - Latching falls turn off; off mode ignores
// - Live mode follows input level
// - Fault pin low when selected bit set
// - No source selected holds fault high
`timescale 1ns/1ps
module rptc_top #(
  parameter int unsigned TRIG_CYC = rptc_pkg::TRIG_MIN_CYC,
  parameter int unsigned SEC_CYC  = rptc_pkg::SEC_CYC
) (
  // Clock and reset
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  // APB slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic [31:0]                        prdata,
  output logic                               pready,
  output logic                               pslverr,
  // Rear port pins
  input  wire logic                          shutdown_pin_i,
  output logic                               fault_pin_o,
  output logic                               fault_pin_oe,
  // Instrument side
  input  wire logic                          key_trig_i,
  input  wire logic [3:0]                    status_sum_i,
  input  wire logic                          step_tick_i,
  output logic                               supply_out_en_o,
  output logic                               trig_o,
  output logic                               list_active_o,
  output logic [rptc_pkg::STEP_W-1:0]        list_step_o,
  output logic                               irq_o
);
  import rptc_pkg::*;

  // Bus request bundle
  rptc_apb_req_t req;
  assign req = '{psel, penable, pwrite, paddr, pwdata};

  // Registers
  rptc_cfg_t          cfg_q;
  logic [TMR_W-1:0]   tmr_set_q;
  logic [STEP_W-1:0]  list_len_q;
  logic               dout_q;
  logic [IRQ_W-1:0]   irq_stat_q;
  logic [IRQ_W-1:0]   irq_mask_q;
  logic [31:0]        prdata_q;
  logic               pready_q;
  logic               pslverr_q;
  logic               sync1_q;
  logic               sync2_q;
  logic               pin_q;
  logic [17:0]        pulse_cnt_q;
  logic               pulse_hit_q;
  logic               on_q;
  logic               out_en_q;
  logic               trig_q;
  logic [TMR_W-1:0]   tmr_cnt_q;
  logic               tmr_run_q;
  logic [25:0]        sec_cnt_q;
  logic               fault_q;
  logic               fault_oe_q;
  logic               irq_q;
  logic               list_act_q;

  // Bus decode
  wire setup_acc = req.psel & req.penable & ~pready_q;
  wire acc       = req.psel & req.penable & pready_q;
  wire wr        = acc & req.pwrite;
  // Read-clear acts where read data is latched, so no event is lost
  wire rd        = setup_acc & ~req.pwrite;
  wire hit_ctrl  = (req.paddr == OFS_CTRL);
  wire hit_tmr   = (req.paddr == OFS_TIMER);
  wire hit_list  = (req.paddr == OFS_LIST);
  wire hit_dout  = (req.paddr == OFS_DOUT);
  wire hit_cmd   = (req.paddr == OFS_CMD);
  wire hit_stat  = (req.paddr == OFS_STAT);
  wire hit_ist   = (req.paddr == OFS_IRQ_STAT);
  wire hit_imsk  = (req.paddr == OFS_IRQ_MASK);
  wire mapped    = hit_ctrl | hit_tmr | hit_list | hit_dout | hit_cmd
                 | hit_stat | hit_ist | hit_imsk;
  wire [4:0] cmd = (wr & hit_cmd) ? req.pwdata[4:0] : 5'h00;

  // Port function views
  wire mode_trig = (cfg_q.port_mode == PM_TRIG);
  wire mode_inh  = (cfg_q.port_mode == PM_INH);
  wire mode_dio  = (cfg_q.port_mode == PM_DIO);

  // External pulse qualification: high for the minimum width
  // Hit flag allows one trigger per high pulse
  wire pin_fall   = pin_q & ~sync2_q;
  wire pulse_full = (pulse_cnt_q == 18'(TRIG_CYC - 1));
  wire ext_trig   = mode_trig & sync2_q & pulse_full & ~pulse_hit_q;

  // Source selection
  wire key_sel  = (cfg_q.trig_src == TS_KEY) & key_trig_i;
  wire ext_sel  = (cfg_q.trig_src == TS_EXT) & ext_trig;
  wire bus_sel  = (cfg_q.trig_src == TS_BUS) & cmd[CMD_BUS_TRIG];
  wire trig_any = key_sel | ext_sel | bus_sel;

  // Inhibit
  // Latch acts on a synced fall only, never on a reset artefact
  wire inh_latch = mode_inh & (cfg_q.inh_mode == IM_LATCH) & pin_fall;
  wire inh_live  = mode_inh & (cfg_q.inh_mode == IM_LIVE) & ~sync2_q;
  wire remote_output_inhibit = inh_latch | inh_live;

  // Output timer
  // Expiry at the 1-to-0 step, only while running
  wire sec_tick  = (sec_cnt_q == 26'(SEC_CYC - 1));
  wire tmr_fire  = tmr_run_q & sec_tick & (tmr_cnt_q <= 16'h0001);
  wire turn_on   = cmd[CMD_OUT_ON] & ~on_q;
  wire on_d      = (on_q | cmd[CMD_OUT_ON]) & ~cmd[CMD_OUT_OFF] & ~tmr_fire
                 & ~inh_latch;

  // Fault source selection, active low
  // Illegal codes fall to off, pin held high
  logic fault_bit;
  always_comb begin
    unique case (cfg_q.fault_src)
      FS_QUES: fault_bit = status_sum_i[0];
      FS_OPER: fault_bit = status_sum_i[1];
      FS_ESB:  fault_bit = status_sum_i[2];
      FS_RQS:  fault_bit = status_sum_i[3];
      default: fault_bit = 1'b0;
    endcase
  end
  wire fault_flag_output = ~fault_bit;
  wire fault_d = mode_inh ? fault_flag_output : (mode_dio ? dout_q : 1'b1);

  // List sequencer
  // Any selected source starts or steps the list
  logic              list_done;
  logic              list_run;
  logic [STEP_W-1:0] list_step;
  rptc_list_seq u_list (
    .pclk      (pclk),
    .presetn   (presetn),
    .trig      (trig_any),
    .arm       (cmd[CMD_LIST_ARM]),
    .stop      (cmd[CMD_LIST_STOP]),
    .step_mode (cfg_q.list_step),
    .repeat_en (cfg_q.list_repeat),
    .steps     (list_len_q),
    .step_tick (step_tick_i),
    .running   (list_run),
    .step      (list_step),
    .done      (list_done)
  );

  // Interrupt events, set wins over read clear
  // Irq output lags status by one cycle
  wire [IRQ_W-1:0] irq_evt = {list_done, (on_q & remote_output_inhibit),
                              (tmr_fire & on_q), trig_any};
  wire [IRQ_W-1:0] irq_clr = (rd & hit_ist) ? {IRQ_W{1'b1}} : '0;

  // Read mux
  logic [31:0] rdata;
  always_comb begin
    rdata = 32'h0000_0000;
    if (hit_ctrl) rdata[11:0] = cfg_q;
    if (hit_tmr)  rdata[TMR_W-1:0] = tmr_set_q;
    if (hit_list) rdata[STEP_W-1:0] = list_len_q;
    if (hit_dout) rdata[0] = dout_q;
    if (hit_stat) begin
      rdata[STAT_PIN]    = sync2_q & mode_dio;
      rdata[STAT_OUT_EN] = out_en_q;
      rdata[STAT_LIST]   = list_run;
      rdata[STAT_STEP_L +: STEP_W] = list_step;
      rdata[STAT_TMR_L +: TMR_W]   = tmr_cnt_q;
    end
    if (hit_ist)  rdata[IRQ_W-1:0] = irq_stat_q;
    if (hit_imsk) rdata[IRQ_W-1:0] = irq_mask_q;
  end

  // APB handshake: one wait state
  // Unmapped addresses answer with an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= setup_acc;
      pslverr_q <= setup_acc & ~mapped;
      if (setup_acc) prdata_q <= req.pwrite ? 32'h0000_0000 : rdata;
    end
  end

  // Software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q      <= rptc_cfg_t'(CTRL_RST);
      tmr_set_q  <= TIMER_RST;
      list_len_q <= LIST_RST;
      dout_q     <= 1'b0;
      irq_mask_q <= '0;
    end else if (wr) begin
      if (hit_ctrl) cfg_q <= rptc_cfg_t'(req.pwdata[11:0]);
      if (hit_tmr)  tmr_set_q <= req.pwdata[TMR_W-1:0];
      if (hit_list) list_len_q <= req.pwdata[STEP_W-1:0];
      if (hit_dout) dout_q <= req.pwdata[0];
      if (hit_imsk) irq_mask_q <= req.pwdata[IRQ_W-1:0];
    end
  end

  // Pin synchronizer and pulse width counter
  // Idle-high reset: no false falling edge after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q     <= 1'b1;
      sync2_q     <= 1'b1;
      pin_q       <= 1'b1;
      pulse_cnt_q <= '0;
      pulse_hit_q <= 1'b0;
    end else begin
      sync1_q <= shutdown_pin_i;
      sync2_q <= sync1_q;
      pin_q   <= sync2_q;
      if (!sync2_q) begin
        pulse_cnt_q <= '0;
        pulse_hit_q <= 1'b0;
      end else if (pulse_full) begin
        pulse_hit_q <= 1'b1;
      end else begin
        pulse_cnt_q <= pulse_cnt_q + 18'h00001;
      end
    end
  end

  // Output state, timer and pins
  // Timer loads only on an off-to-on change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_q       <= 1'b0;
      out_en_q   <= 1'b0;
      trig_q     <= 1'b0;
      tmr_run_q  <= 1'b0;
      tmr_cnt_q  <= '0;
      sec_cnt_q  <= '0;
      fault_q    <= 1'b1;
      fault_oe_q <= 1'b0;
      irq_stat_q <= '0;
      irq_q      <= 1'b0;
      list_act_q <= 1'b0;
    end else begin
      on_q       <= on_d;
      out_en_q   <= on_d & ~inh_live;
      trig_q     <= trig_any;
      fault_q    <= fault_d;
      // Trigger mode and illegal codes leave the pin undriven
      fault_oe_q <= mode_inh | mode_dio;
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_evt;
      irq_q      <= |(irq_stat_q & irq_mask_q);
      list_act_q <= list_run;
      if (turn_on & cfg_q.timer_en) begin
        tmr_run_q <= 1'b1;
        tmr_cnt_q <= tmr_set_q;
        sec_cnt_q <= '0;
      end else if (!on_d || !cfg_q.timer_en) begin
        tmr_run_q <= 1'b0;
        tmr_cnt_q <= '0;
        sec_cnt_q <= '0;
      end else if (tmr_run_q) begin
        sec_cnt_q <= sec_tick ? '0 : sec_cnt_q + 26'h0000001;
        if (sec_tick) tmr_cnt_q <= tmr_cnt_q - 16'h0001;
      end
    end
  end

  assign prdata          = prdata_q;
  assign pready          = pready_q;
  assign pslverr         = pslverr_q;
  assign fault_pin_o     = fault_q;
  assign fault_pin_oe    = fault_oe_q;
  assign supply_out_en_o = out_en_q;
  assign trig_o          = trig_q;
  assign list_active_o   = list_act_q;
  assign list_step_o     = list_step;
  assign irq_o           = irq_q;
endmodule : rptc_top

/* dv/rptc_props.sv */
/* Port checker for rptc_top, bound to every instance.
   Assumes one pclk domain and asynchronous active-low reset. */
`timescale 1ns/1ps
module rptc_props (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Port and instrument
  input wire logic        shutdown_pin_i,
  input wire logic        fault_pin_o,
  input wire logic        key_trig_i,
  input wire logic        supply_out_en_o,
  input wire logic        trig_o
);
  import rptc_pkg::*;
  wire acc1 = psel && penable && !pready;
  wire wr_c = psel && penable && pready && pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_pready_wait: assert property (acc1 |=> pready)
    else $error("access not answered after one wait");
  a_pready_once: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_err_unmapped: assert property (acc1 && paddr > OFS_IRQ_MASK |=> pslverr)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (acc1 && paddr <= OFS_IRQ_MASK && paddr[1:0] == 2'h0
    |=> !pslverr)
    else $error("mapped access refused");
  a_cmd_zero: assert property (acc1 && !pwrite && paddr == OFS_CMD |=> prdata == 32'h0)
    else $error("command word reads nonzero");
  a_trig_pulse: assert property (trig_o |=> !trig_o)
    else $error("trigger longer than one cycle");
  a_trig_cause: assert property (trig_o |-> $past(key_trig_i) || $past(key_trig_i, 2)
    || $past(wr_c) || $past(wr_c, 2) || $past(shutdown_pin_i, 3))
    else $error("trigger without a cause");
  a_reset_safe: assert property ($rose(presetn)
    |-> !supply_out_en_o && fault_pin_o && !trig_o)
    else $error("outputs unsafe after reset");
endmodule : rptc_props

bind rptc_top rptc_props u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .shutdown_pin_i(shutdown_pin_i), .fault_pin_o(fault_pin_o),
  .key_trig_i(key_trig_i), .supply_out_en_o(supply_out_en_o), .trig_o(trig_o)
);

/* dv/rptc_pin_model.sv */
/* External TTL equipment on the rear port.
   Assumes tasks are called from the bench; pulled-up fault line. */
`timescale 1ns/1ps
module rptc_pin_model (
  // Clock
  input wire logic pclk,
  // Rear port
  output logic     pin,
  input wire logic fault_pin_o,
  input wire logic fault_pin_oe,
  output logic     fault_line
);
  initial pin = 1'b1;
  assign fault_line = fault_pin_oe ? fault_pin_o : 1'b1;
  task automatic level(input logic v);
    @(posedge pclk);
    pin <= v;
  endtask : level
  // High for hi cycles, then low with a gap
  task automatic pulse(input int hi);
    @(posedge pclk);
    pin <= 1'b1;
    repeat (hi) @(posedge pclk);
    pin <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask : pulse
endmodule : rptc_pin_model

/* dv/tb_top.sv */
/* Self-checking bench for rptc_top.
   Assumes the pin model drives the rear port pin. */
`timescale 1ns/1ps
module tb_top;
  import rptc_pkg::*;
  localparam int TC = 8;
  localparam int SC = 16;
  logic        pclk, presetn, psel, penable, pwrite, key, tick, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [3:0]  st;
  logic        pready, pslverr, pin, fpo, foe, sup, trg, act, irq, fline;
  logic [7:0]  stp;
  int          n_fail, tests_run, ntrig, k, t0;
  logic [31:0] rst_v[5] = '{32'h0, 32'h0, 32'h1, 32'h0, 32'h0};
  always #10 pclk = ~pclk;
  always @(posedge pclk) if (trg === 1'b1) ntrig++;
  rptc_top #(.TRIG_CYC(TC), .SEC_CYC(SC)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .shutdown_pin_i(pin), .fault_pin_o(fpo), .fault_pin_oe(foe), .key_trig_i(key),
    .status_sum_i(st), .step_tick_i(tick), .supply_out_en_o(sup), .trig_o(trg),
    .list_active_o(act), .list_step_o(stp), .irq_o(irq));
  rptc_pin_model pm (.pclk(pclk), .pin(pin), .fault_pin_o(fpo), .fault_pin_oe(foe),
    .fault_line(fline));
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_fail++;
      print_verdict();
    end
    rv = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  initial begin
    pclk = 0;
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    key = 0;
    tick = 0;
    st = 0;
    void'($urandom(36));
    cyc(16);
    presetn <= 1'b1;
    foreach (rst_v[i]) begin
      apb(0, 8'(i * 4), 0);
      chk("reset value", rv, rst_v[i]);
    end
    apb(1, 8'h20, 32'hffffffff);
    chk("unmapped err", er, 1);
    apb(0, 8'h20, 0);
    chk("unmapped data", rv, 0);
    t0 = 32'({3'($urandom), 3'($urandom % 5), 2'($urandom % 3),
              2'($urandom % 3), 2'($urandom % 3)});
    apb(1, OFS_CTRL, t0);
    apb(0, OFS_CTRL, 0);
    chk("ctrl readback", rv, t0);
    apb(1, OFS_IRQ_MASK, 32'h1);
    for (int s = 0; s < 3; s++) begin
      apb(1, OFS_CTRL, s << 2);
      pm.level(0);
      t0 = ntrig;
      @(posedge pclk) key <= 1'b1;
      @(posedge pclk) key <= 1'b0;
      apb(1, OFS_CMD, 32'h1 << CMD_BUS_TRIG);
      pm.pulse(TC - 3);
      pm.pulse(TC + 4);
      chk("one trigger", ntrig - t0, 1);
      chk("trig oe", foe, 0);
      chk("irq raised", irq, 1);
      apb(0, OFS_IRQ_STAT, 0);
      chk("irq stat", rv[IRQ_TRIG], 1);
      apb(0, OFS_IRQ_STAT, 0);
      chk("irq cleared", rv[IRQ_TRIG], 0);
      chk("irq low", irq, 0);
    end
    for (int f = 0; f < 5; f++) begin
      st <= 4'($urandom);
      apb(1, OFS_CTRL, 1 | (f << 6));
      cyc(2);
      chk("fault oe", foe, 1);
      chk("fault pin", fline, f == 0 ? 1 : !st[f - 1]);
    end
    apb(1, OFS_CTRL, 2);
    for (int v = 0; v < 2; v++) begin
      apb(1, OFS_DOUT, v);
      pm.level(v[0]);
      cyc(4);
      chk("dout", fline, v);
      apb(0, OFS_STAT, 0);
      chk("din", rv[STAT_PIN], v);
    end
    foreach (rst_v[m]) if (m < 3) begin
      apb(1, OFS_CTRL, 1 | (m << 4));
      pm.level(1);
      apb(1, OFS_CMD, 32'h1 << CMD_OUT_ON);
      cyc(6);
      chk("out on", sup, 1);
      pm.level(0);
      cyc(8);
      chk("inhibit low", sup, m == 0);
      pm.level(1);
      cyc(8);
      chk("inhibit high", sup, m != 1);
      apb(1, OFS_CMD, 32'h1 << CMD_OUT_OFF);
    end
    apb(1, OFS_TIMER, 3);
    apb(1, OFS_CTRL, 32'h1 << 11);
    apb(1, OFS_CMD, 32'h1 << CMD_OUT_ON);
    cyc(2);
    k = 0;
    while (sup === 1'b1 && k < 200) begin
      @(posedge pclk);
      k++;
    end
    if (sup === 1'b1) begin
      n_fail++;
      print_verdict();
    end
    chk("timer span", k >= 3 * SC - 4 && k <= 3 * SC + 4, 1);
    apb(0, OFS_IRQ_STAT, 0);
    chk("timer irq", rv[IRQ_TIMER], 1);
    apb(1, OFS_LIST, 3);
    apb(1, OFS_CTRL, (1 << 2) | (1 << 9));
    pm.level(0);
    apb(1, OFS_CMD, 32'h1 << CMD_LIST_ARM);
    cyc(2);
    chk("list armed", act, 1);
    k = 0;
    t0 = 0;
    while (act === 1'b1 && k < 6) begin
      pm.pulse(TC + 4);
      k++;
      t0 = (t0 + 1) % 3;
      chk("list step", stp, t0);
    end
    chk("list steps", k, 3);
    apb(0, OFS_IRQ_STAT, 0);
    chk("list done", rv[IRQ_LIST_DONE], 1);
    apb(1, OFS_LIST, 2);
    apb(1, OFS_CTRL, (2 << 2) | (1 << 10));
    apb(1, OFS_CMD, 32'h1 << CMD_LIST_ARM);
    apb(1, OFS_CMD, 32'h1 << CMD_BUS_TRIG);
    for (int p = 1; p <= 4; p++) begin
      @(posedge pclk) tick <= 1'b1;
      @(posedge pclk) tick <= 1'b0;
      cyc(2);
      chk("cont step", stp, p % 2);
      chk("cont running", act, 1);
    end
    apb(1, OFS_CMD, 32'h1 << CMD_LIST_STOP);
    cyc(2);
    chk("list stopped", act, 0);
    apb(0, OFS_IRQ_STAT, 0);
    chk("repeat no done", rv[IRQ_LIST_DONE], 0);
    print_verdict();
  end
endmodule : tb_top
